// File: rtl/epd_top.sv
// Encoder pulse divider with electronic gear and Wishbone register slave
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Overview of operation
// - Divided A, B, C outputs as complementary pairs
// - A/B pulses per revolution equal dividing setting
// - Incremental type accepts settings 16 to 2048
// - Absolute type accepts settings 16 to 1024
// - Type bit defaults 0 incremental, 1 absolute
// - Type takes effect only at start-up
// - Divider ignores gear numerator and denominator
// - Serial output pair and sensor request input
// - Reference pulses scaled by electronic gear
// - One reference pulse moves one reference unit
// - Four position counts per encoder pulse
// - Gear numerator/denominator 1..65535, default 1
module epd_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Motor encoder and stored type selection
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_z_i,
    input wire logic enc_serial_i,
    input wire logic enc_type_sel_i,
    // Reference pulse train, pulse plus sign
    input wire logic ref_pulse_i,
    input wire logic ref_sign_i,
    input wire logic sensor_request_in_i,
    input wire logic sensor_request_in_n_i,
    output logic div_phase_a_out_o,
    output logic div_phase_a_out_n_o,
    output logic div_phase_b_out_o,
    output logic div_phase_b_out_n_o,
    output logic div_index_out_o,
    output logic div_index_out_n_o,
    output logic abs_serial_out_o,
    output logic abs_serial_out_n_o
);
    import epd_pkg::*;

    // Gray order 00,01,11,10 maps to quadrature state 0..3
    function automatic logic [1:0] quad_state(input logic a, input logic b);
        return {a, a ^ b};
    endfunction

    logic [8:0] pin_s;
    epd_sync #(.W(9)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({enc_a_i, enc_b_i, enc_z_i, enc_serial_i, enc_type_sel_i,
              ref_pulse_i, ref_sign_i, sensor_request_in_i, sensor_request_in_n_i}),
        .q_o(pin_s)
    );
    logic enc_a_s, enc_b_s, enc_z_s, enc_ser_s, type_s, ref_p_s, ref_d_s;
    logic sen_p_s, sen_n_s, sen_s;
    assign {enc_a_s, enc_b_s, enc_z_s, enc_ser_s, type_s,
            ref_p_s, ref_d_s, sen_p_s, sen_n_s} = pin_s;
    // Pair decoded only after both legs are synchronised
    assign sen_s = sen_p_s & ~sen_n_s;

    // ---------------- Start-up type capture ----------------
    logic [1:0] boot_cnt_r, boot_cnt_nxt;
    logic type_act_r, type_act_nxt;
    logic [11:0] ppr;
    logic boot_done;
    always_comb begin
        boot_cnt_nxt = boot_cnt_r;
        type_act_nxt = type_act_r;
        if (boot_cnt_r != EPD_STARTUP_WAIT) begin
            boot_cnt_nxt = boot_cnt_r + 2'h1;
            type_act_nxt = type_s;
        end
    end
    assign ppr = (type_act_r == EPD_TYPE_ABS) ? EPD_PPR_ABS : EPD_PPR_INC;
    assign boot_done = (boot_cnt_r == EPD_STARTUP_WAIT);

    // ---------------- Wishbone registers ----------------
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic [11:0] div_r, div_nxt;
    logic [15:0] num_r, num_nxt, den_r, den_nxt;
    logic reject_r, reject_nxt;
    logic [31:0] enc_pos_r, enc_pos_nxt, cmd_pos_r, cmd_pos_nxt;
    logic wr_en;
    logic div_ok;
    logic [31:0] wdat;

    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wdat[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : 8'h00;
        end
    end
    // Whole setting must be in range; a rejected write leaves the old value
    assign div_ok = (wdat[31:12] == 20'h0) && (wdat[11:0] >= EPD_DIV_MIN)
                    && (wdat[11:0] <= ppr);

    always_comb begin
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        rdat_nxt = 32'h0;
        div_nxt = div_r;
        num_nxt = num_r;
        den_nxt = den_r;
        reject_nxt = reject_r;
        if (wr_en) begin
            case (wb_adr_i)
                EPD_OFS_CTRL: begin
                    if (wb_sel_i[0] && wb_dat_i[EPD_BIT_REJECT]) begin
                        reject_nxt = 1'b0;
                    end
                end
                EPD_OFS_DIV: begin
                    if (div_ok) begin
                        div_nxt = wdat[11:0];
                    end else begin
                        reject_nxt = 1'b1;
                    end
                end
                EPD_OFS_NUM: begin
                    if (wdat[15:0] != 16'h0) begin
                        num_nxt = wdat[15:0];
                    end else begin
                        reject_nxt = 1'b1;
                    end
                end
                EPD_OFS_DEN: begin
                    if (wdat[15:0] != 16'h0) begin
                        den_nxt = wdat[15:0];
                    end else begin
                        reject_nxt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
            case (wb_adr_i)
                EPD_OFS_CTRL: begin
                    rdat_nxt[EPD_BIT_TYPE_ACT] = type_act_r;
                    rdat_nxt[EPD_BIT_REJECT] = reject_r;
                    rdat_nxt[EPD_BIT_TYPE_SET] = type_s;
                end
                EPD_OFS_DIV: rdat_nxt = {20'h0, div_r};
                EPD_OFS_NUM: rdat_nxt = {16'h0, num_r};
                EPD_OFS_DEN: rdat_nxt = {16'h0, den_r};
                EPD_OFS_ENC_POS: rdat_nxt = enc_pos_r;
                EPD_OFS_CMD_POS: rdat_nxt = cmd_pos_r;
                default: rdat_nxt = 32'h0;
            endcase
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ---------------- Encoder decode and divider ----------------
    logic [1:0] enc_q_prev_r, enc_q_prev_nxt, enc_q, enc_delta;
    logic enc_fwd, enc_rev;
    logic signed [13:0] dacc_r, dacc_nxt, dsum;
    logic [1:0] out_q_r, out_q_nxt;
    logic idx_r, idx_nxt;
    logic ser_r, ser_nxt;

    assign enc_q = quad_state(enc_a_s, enc_b_s);
    assign enc_delta = enc_q - enc_q_prev_r;
    // Synchronisers filling after reset look like motion; ignore them
    assign enc_fwd = (enc_delta == 2'h1) && boot_done;
    assign enc_rev = (enc_delta == 2'h3) && boot_done;

    // Each forward edge adds the setting, each reverse edge subtracts it; every ppr worth steps the output
    // state once, so 4*ppr edges give 4*setting steps, i.e. setting pulses
    always_comb begin
        enc_q_prev_nxt = enc_q;
        enc_pos_nxt = enc_pos_r;
        dacc_nxt = dacc_r;
        out_q_nxt = out_q_r;
        dsum = dacc_r;
        if (enc_fwd) begin
            enc_pos_nxt = enc_pos_r + 32'h1;
            dsum = dacc_r + $signed({2'b00, div_r});
            if (dsum >= $signed({2'b00, ppr})) begin
                dsum = dsum - $signed({2'b00, ppr});
                out_q_nxt = out_q_r + 2'h1;
            end
        end else if (enc_rev) begin
            enc_pos_nxt = enc_pos_r - 32'h1;
            dsum = dacc_r - $signed({2'b00, div_r});
            if (dsum < 14'sh0) begin
                dsum = dsum + $signed({2'b00, ppr});
                out_q_nxt = out_q_r - 2'h1;
            end
        end
        dacc_nxt = dsum;
        idx_nxt = enc_z_s;
        ser_nxt = (type_act_r == EPD_TYPE_ABS) && sen_s && enc_ser_s;
    end

    // Phase A taken from a state flop, phase B from the XOR of both state flops; each complement from the same term
    assign div_phase_a_out_o = out_q_r[1];
    assign div_phase_a_out_n_o = ~out_q_r[1];
    assign div_phase_b_out_o = out_q_r[1] ^ out_q_r[0];
    assign div_phase_b_out_n_o = ~(out_q_r[1] ^ out_q_r[0]);
    assign div_index_out_o = idx_r;
    assign div_index_out_n_o = ~idx_r;
    assign abs_serial_out_o = ser_r;
    assign abs_serial_out_n_o = ~ser_r;

    // ---------------- Reference pulses through the gear ----------------
    logic ref_p_d_r, ref_p_d_nxt;
    logic ref_edge;
    logic g_step, g_dir;
    assign ref_edge = ref_p_s & ~ref_p_d_r;

    epd_gear u_gear (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_pulse_i(ref_edge),
        .ref_dir_i(ref_d_s),
        .num_i(num_r),
        .den_i(den_r),
        .step_o(g_step),
        .dir_o(g_dir)
    );

    always_comb begin
        ref_p_d_nxt = ref_p_s;
        cmd_pos_nxt = cmd_pos_r;
        if (g_step) begin
            cmd_pos_nxt = g_dir ? cmd_pos_r - 32'h1 : cmd_pos_r + 32'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_cnt_r <= 2'h0;
            type_act_r <= EPD_TYPE_INC;
            ack_r <= 1'b0;
            rdat_r <= 32'h0;
            div_r <= EPD_DIV_DEF;
            num_r <= EPD_GEAR_DEF;
            den_r <= EPD_GEAR_DEF;
            reject_r <= 1'b0;
            enc_pos_r <= 32'h0;
            cmd_pos_r <= 32'h0;
            enc_q_prev_r <= 2'h0;
            dacc_r <= 14'sh0;
            out_q_r <= 2'h0;
            idx_r <= 1'b0;
            ser_r <= 1'b0;
            ref_p_d_r <= 1'b0;
        end else begin
            boot_cnt_r <= boot_cnt_nxt;
            type_act_r <= type_act_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            div_r <= div_nxt;
            num_r <= num_nxt;
            den_r <= den_nxt;
            reject_r <= reject_nxt;
            enc_pos_r <= enc_pos_nxt;
            cmd_pos_r <= cmd_pos_nxt;
            enc_q_prev_r <= enc_q_prev_nxt;
            dacc_r <= dacc_nxt;
            out_q_r <= out_q_nxt;
            idx_r <= idx_nxt;
            ser_r <= ser_nxt;
            ref_p_d_r <= ref_p_d_nxt;
        end
    end

    // ---------------- Assertions ----------------
    a_div_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (div_r >= EPD_DIV_MIN) && (div_r <= EPD_PPR_INC))
        else $error("dividing setting out of range");
    a_abs_div_reject: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_en && wb_adr_i == EPD_OFS_DIV && type_act_r && wdat > {20'h0, EPD_PPR_ABS})
        |=> reject_r && $stable(div_r))
        else $error("absolute type accepted setting above 1024");
    a_type_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        (boot_cnt_r == EPD_STARTUP_WAIT) |=> $stable(type_act_r))
        else $error("encoder type changed while running");
    a_type_default: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (type_act_r == EPD_TYPE_INC))
        else $error("encoder type not zero after reset");
    a_out_step_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (out_q_r != $past(out_q_r)) |->
        ((out_q_r - $past(out_q_r)) == 2'h1 || (out_q_r - $past(out_q_r)) == 2'h3))
        else $error("divided output skipped a quadrature state");
    a_out_needs_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        !(enc_fwd || enc_rev) |=> $stable(out_q_r))
        else $error("divided output moved without encoder edge");
    a_full_div_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        (enc_fwd && div_r == ppr && !$past(enc_fwd) && !$past(enc_rev))
        |=> (out_q_r == $past(out_q_r) + 2'h1))
        else $error("full dividing setting did not follow encoder");
    a_enc_count: assert property (@(posedge clk_i) disable iff (rst_i)
        enc_fwd |=> (enc_pos_r == $past(enc_pos_r) + 32'h1))
        else $error("position count missed an encoder edge");
    a_gear_unity: assert property (@(posedge clk_i) disable iff (rst_i)
        (ref_edge && num_r == 16'h1 && den_r == 16'h1 && !g_step) |-> ##2 g_step)
        else $error("unity gear did not yield one count");
    a_gear_nonzero: assert property (@(posedge clk_i) disable iff (rst_i)
        (num_r != 16'h0) && (den_r != 16'h0))
        else $error("gear setting reached zero");
    a_complement: assert property (@(posedge clk_i) disable iff (rst_i)
        (div_phase_a_out_o != div_phase_a_out_n_o) && (div_index_out_o != div_index_out_n_o))
        else $error("output pair not complementary");
    a_serial_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !sen_s |=> !abs_serial_out_o)
        else $error("serial output without sensor request");
    a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule // epd_top

// File: include/epd_pkg.sv
// Constants shared by the encoder pulse divider and electronic gear design
package epd_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] EPD_OFS_CTRL = 8'h00;
    localparam logic [7:0] EPD_OFS_DIV = 8'h04;
    localparam logic [7:0] EPD_OFS_NUM = 8'h08;
    localparam logic [7:0] EPD_OFS_DEN = 8'h0c;
    localparam logic [7:0] EPD_OFS_ENC_POS = 8'h10;
    localparam logic [7:0] EPD_OFS_CMD_POS = 8'h14;
    // Field positions in the control and status word
    localparam int EPD_BIT_TYPE_ACT = 0;
    localparam int EPD_BIT_REJECT = 1;
    localparam int EPD_BIT_TYPE_SET = 2;
    // Encoder types and resolutions
    localparam logic EPD_TYPE_INC = 1'b0;
    localparam logic EPD_TYPE_ABS = 1'b1;
    localparam logic [11:0] EPD_PPR_INC = 12'h800;
    localparam logic [11:0] EPD_PPR_ABS = 12'h400;
    // Dividing setting limits and reset values
    localparam logic [11:0] EPD_DIV_MIN = 12'h010;
    localparam logic [11:0] EPD_DIV_DEF = 12'h800;
    localparam logic [15:0] EPD_GEAR_DEF = 16'h0001;
    // Cycles after reset release before the type straps are trusted
    localparam logic [1:0] EPD_STARTUP_WAIT = 2'h3;
endpackage

// File: rtl/epd_sync.sv
// Two-flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module epd_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    import epd_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule // epd_sync

// File: rtl/epd_gear.sv
// Electronic gear: turns each reference pulse into num/den position counts
`timescale 1ns/1ns
module epd_gear (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_pulse_i,
    input wire logic ref_dir_i,
    input wire logic [15:0] num_i,
    input wire logic [15:0] den_i,
    output logic step_o,
    output logic dir_o
);
    import epd_pkg::*;

    logic [17:0] acc_r;
    logic [17:0] acc_nxt;
    logic dir_r;
    logic dir_nxt;
    logic step_r;
    logic step_nxt;

    // One count leaves per cycle while the remainder holds a whole one;
    // a ratio of at most 100 keeps this well ahead of the pulse rate
    always_comb begin
        acc_nxt = acc_r;
        dir_nxt = dir_r;
        step_nxt = 1'b0;
        if (acc_r >= {2'b00, den_i}) begin
            acc_nxt = acc_r - {2'b00, den_i};
            step_nxt = 1'b1;
        end
        if (ref_pulse_i) begin
            acc_nxt = acc_nxt + {2'b00, num_i};
            dir_nxt = ref_dir_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_r <= '0;
            dir_r <= 1'b0;
            step_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            dir_r <= dir_nxt;
            step_r <= step_nxt;
        end
    end

    assign step_o = step_r;
    assign dir_o = dir_r;
endmodule // epd_gear

// File: dv/epd_host_model.sv
// Host controller model: decodes the divided quadrature and index pairs
`timescale 1ns/1ns
module epd_host_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic a_i,
    input wire logic a_n_i,
    input wire logic b_i,
    input wire logic b_n_i,
    input wire logic c_i,
    input wire logic c_n_i,
    output int pos_o,
    output int pair_err_o,
    output int index_o,
    output int skip_o
);
    logic [1:0] prev_r;
    logic [1:0] delta;
    logic c_r;
    always @(posedge clk_i) begin
        delta = {a_i, a_i ^ b_i} - prev_r;
        prev_r <= {a_i, a_i ^ b_i};
        c_r <= c_i;
        if (rst_i) begin
            pos_o <= 0;
            pair_err_o <= 0;
            index_o <= 0;
            skip_o <= 0;
        end else begin
            // B lead counts up, A lead counts down; a jump of two states is a fault
            if (delta == 2'h1) pos_o <= pos_o + 1;
            if (delta == 2'h3) pos_o <= pos_o - 1;
            if (delta == 2'h2) skip_o <= skip_o + 1;
            if ({a_i, b_i, c_i} !== ~{a_n_i, b_n_i, c_n_i}) pair_err_o <= pair_err_o + 1;
            if (c_i && !c_r) index_o <= index_o + 1;
        end
    end
endmodule // epd_host_model

// File: dv/tb.sv
// Self-checking bench for the encoder pulse divider and electronic gear
`timescale 1ns/1ns
module tb;
    import epd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o;
    logic enc_a_i = 1'b0, enc_b_i = 1'b0, enc_z_i = 1'b0, enc_serial_i = 1'b0;
    logic enc_type_sel_i = 1'b0, ref_pulse_i = 1'b0, ref_sign_i = 1'b0;
    logic sensor_request_in_i = 1'b0, sensor_request_in_n_i = 1'b1;
    logic pa, pa_n, pb, pb_n, pc, pc_n, ps, ps_n;
    logic [1:0] ph = 2'h0;
    int pos, pair_err, idx, skip;
    int bad_count = 0;
    int comparisons = 0;
    always #10 clk_i = ~clk_i;
    epd_top i_epd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
        .enc_z_i(enc_z_i), .enc_serial_i(enc_serial_i), .enc_type_sel_i(enc_type_sel_i),
        .ref_pulse_i(ref_pulse_i), .ref_sign_i(ref_sign_i),
        .sensor_request_in_i(sensor_request_in_i), .sensor_request_in_n_i(sensor_request_in_n_i),
        .div_phase_a_out_o(pa), .div_phase_a_out_n_o(pa_n), .div_phase_b_out_o(pb),
        .div_phase_b_out_n_o(pb_n), .div_index_out_o(pc), .div_index_out_n_o(pc_n),
        .abs_serial_out_o(ps), .abs_serial_out_n_o(ps_n));
    epd_host_model i_epd_host_model (.clk_i(clk_i), .rst_i(rst_i), .a_i(pa), .a_n_i(pa_n),
        .b_i(pb), .b_n_i(pb_n), .c_i(pc), .c_n_i(pc_n), .pos_o(pos), .pair_err_o(pair_err),
        .index_o(idx), .skip_o(skip));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                        input logic [3:0] sel, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) chk("ack", wb_ack_o, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] v);
        logic [31:0] d;
        xfer(1'b1, adr, v, 4'hf, d);
    endtask
    task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, adr, 32'h0, 4'hf, d);
        chk(what, d, exp);
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        // Synchronisers and the type strap window need a few cycles to settle
        repeat (8) @(posedge clk_i);
    endtask
    task automatic enc_steps(input int n, input logic fwd);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            ph = fwd ? ph + 2'h1 : ph - 2'h1;
            enc_a_i <= ph[1];
            enc_b_i <= ph[1] ^ ph[0];
            repeat (3) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_reset();
        rdc("ctrl", EPD_OFS_CTRL, 32'h0);
        rdc("div", EPD_OFS_DIV, 32'h800);
        rdc("num", EPD_OFS_NUM, 32'h1);
        rdc("den", EPD_OFS_DEN, 32'h1);
        wr(8'h20, 32'h5);
        rdc("unmapped", 8'h20, 32'h0);
        rdc("cmd pos", EPD_OFS_CMD_POS, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_limits();
        logic [31:0] d;
        wr(EPD_OFS_DIV, 32'hf);
        rdc("div low", EPD_OFS_DIV, 32'h800);
        rdc("reject", EPD_OFS_CTRL, 32'h2);
        wr(EPD_OFS_CTRL, 32'h2);
        wr(EPD_OFS_DIV, 32'h801);
        rdc("reject high", EPD_OFS_CTRL, 32'h2);
        wr(EPD_OFS_CTRL, 32'h2);
        wr(EPD_OFS_DIV, 32'h10);
        rdc("div min", EPD_OFS_DIV, 32'h10);
        // Only lane 0 enabled; the stray upper byte must not reach the range check
        xfer(1'b1, EPD_OFS_DIV, 32'h0000_0920, 4'h1, d);
        rdc("div lane", EPD_OFS_DIV, 32'h20);
        wr(EPD_OFS_NUM, 32'h0);
        rdc("num zero", EPD_OFS_NUM, 32'h1);
        wr(EPD_OFS_CTRL, 32'h2);
        wr(EPD_OFS_DEN, 32'hffff);
        rdc("den max", EPD_OFS_DEN, 32'hffff);
        rdc("no reject", EPD_OFS_CTRL, 32'h0);
        wr(EPD_OFS_DEN, 32'h1);
        $display("test limits done");
    endtask
    task automatic t_divide(input int ppr, input int dv, input int steps);
        int p0, e0;
        p0 = pos;
        e0 = idx;
        wr(EPD_OFS_DIV, dv);
        wr(EPD_OFS_NUM, 32'h3);
        enc_steps(steps, 1'b1);
        chk("out steps", pos - p0, steps * dv / ppr);
        rdc("enc pos", EPD_OFS_ENC_POS, steps);
        enc_steps(steps, 1'b0);
        chk("out back", pos - p0, 32'h0);
        rdc("enc back", EPD_OFS_ENC_POS, 32'h0);
        @(posedge clk_i);
        enc_z_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("index", pc_n, 32'h0);
        enc_z_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("index count", idx - e0, 32'h1);
        chk("skips", skip, 32'h0);
        chk("pairs", pair_err, 32'h0);
        wr(EPD_OFS_NUM, 32'h1);
        $display("test divide done");
    endtask
    task automatic t_gear();
        int nums[4] = '{3, 1, 1, 100};
        int dens[4] = '{1, 2, 1, 1};
        int cnt[4] = '{5, 4, 3, 2};
        int exp;
        exp = 0;
        // Ratios stay within 0.01 to 100 as the host must keep them
        for (int k = 0; k < 4; k++) begin
            wr(EPD_OFS_NUM, nums[k]);
            wr(EPD_OFS_DEN, dens[k]);
            ref_sign_i <= (k == 2);
            for (int i = 0; i < cnt[k]; i++) begin
                repeat (4) @(posedge clk_i);
                ref_pulse_i <= 1'b1;
                repeat (4) @(posedge clk_i);
                ref_pulse_i <= 1'b0;
                repeat (6 + nums[k]) @(posedge clk_i);
            end
            exp += (k == 2 ? -1 : 1) * cnt[k] * nums[k] / dens[k];
            rdc("cmd pos", EPD_OFS_CMD_POS, exp);
        end
        $display("test gear done");
    endtask
    task automatic t_type();
        enc_type_sel_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rdc("type held", EPD_OFS_CTRL, 32'h4);
        wr(EPD_OFS_DIV, 32'h600);
        rdc("inc limit", EPD_OFS_DIV, 32'h600);
        do_reset();
        rdc("type abs", EPD_OFS_CTRL, 32'h5);
        wr(EPD_OFS_DIV, 32'h401);
        rdc("abs reject", EPD_OFS_CTRL, 32'h7);
        wr(EPD_OFS_CTRL, 32'h2);
        t_divide(1024, 1024, 8);
        sensor_request_in_i <= 1'b1;
        sensor_request_in_n_i <= 1'b0;
        enc_serial_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("serial", {ps, ps_n}, 32'h2);
        enc_serial_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("serial low", {ps, ps_n}, 32'h1);
        sensor_request_in_i <= 1'b0;
        sensor_request_in_n_i <= 1'b1;
        enc_serial_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk("serial idle", {ps, ps_n}, 32'h1);
        $display("test type done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        do_reset();
        t_reset();
        t_limits();
        t_divide(2048, 16, 256);
        t_divide(2048, 1024, 256);
        t_divide(2048, 2048, 256);
        t_gear();
        t_type();
        results();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        $display("Error watchdog expired");
        results();
    end
endmodule // tb
